// ### ewc_pkg.sv
// ewc_pkg: register map, field positions, reset values and states of the wake-event control block
// assumes: included by every ewc file but the ewc_frame_if interface; 32-bit AHB-Lite register bus, device clock only
//
// What this block does
// - PHY status bit set plus PHY wake enable raises a wake event at once in any state but two.
// - PHY pending status bit cannot clear while the PHY interrupt stays high.
// - MAC pending status bit set raises a wake event with LAN wake on outside state two, or with filter wake in state three.
// - MAC pending status bit cannot clear while the MAC wake event stays high.
// - With PHY wake enabled, the unmasked PHY interrupt is the link-change wake source.
// - Link-change wake signals remote wake, returns to normal, records link change.
// - Good-frame wake needs an uncorrupted frame passing the enabled receive filters.
// - After a good-frame wake every later good frame passing the enabled filters is written to the FIFO.
// - The waking frame is stored only when keep-wake-frame is set.
// - Suspend select value 11b decodes as low-power state three.
// - Any enabled wake in state three returns to normal, signals, and records cause unless it is a MAC wake event with LAN wake off.
// - The stored waking frame carries a wake-frame flag in its status word.
// - Wake frame need not be first in FIFO; driver uses the per-frame flag.
// - Frames after the wake frame still need filter pass and good FCS.
// - Bypass bit stores wake frames without applying the receive filters.
package ewc_pkg;

   // register byte offsets
   localparam logic [11:0] PMC_OFFSET  = 12'h000;   // power_mgmt_control
   localparam logic [11:0] WCS1_OFFSET = 12'h004;   // wake_ctrl_status_one
   localparam logic [11:0] RFC_OFFSET  = 12'h008;   // rx_filter_control
   localparam logic [11:0] WSR_OFFSET  = 12'h00C;   // wake_source_register

   // power_mgmt_control fields
   localparam int PMC_PHY_WAKE_ENABLE  = 0;
   localparam int PMC_LAN_WAKE_EN  = 1;
   localparam int PMC_WPS_LO       = 4;   // wake_pending_status [5:4], write one to clear
   localparam int PMC_SUSP_SEL_LO  = 8;   // suspend select [9:8]
   localparam int PMC_CUR_STATE_LO = 12;  // current low-power state [13:12], read only
   localparam int PMC_SUSPENDED    = 14;  // read only

   // wake_ctrl_status_one fields
   localparam int WCS1_FILTER_WAKE_EN = 0;
   localparam int WCS1_KEEP_WAKE      = 1;

   // rx_filter_control fields
   localparam int RFC_BYPASS_WAKE = 0;
   localparam int RFC_FILTER_EN_LO = 8;

   // wake_source_register fields
   localparam int WSR_LINK_CHANGE = 0;
   localparam int WSR_GOOD_FRAME  = 1;
   localparam int WSR_PATTERN     = 2;
   localparam int WSR_WIDTH       = 3;

   // suspend select encodings
   localparam logic [1:0] SUSP_ZERO  = 2'h0;
   localparam logic [1:0] SUSP_ONE   = 2'h1;
   localparam logic [1:0] SUSP_TWO   = 2'h2;
   localparam logic [1:0] SUSP_THREE = 2'h3;

   // reset values
   localparam logic [1:0] SUSP_SEL_RESET = 2'h0;
   localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

   // bus constants
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   typedef enum logic {EWC_NORMAL, EWC_SUSPENDED} ewc_power_t;

   // sticky flag update: a set in the same cycle beats the clear
   function automatic logic [WSR_WIDTH-1:0] ewc_sticky(input logic [WSR_WIDTH-1:0] cur,
                                                       input logic [WSR_WIDTH-1:0] set,
                                                       input logic [WSR_WIDTH-1:0] clr);
      ewc_sticky = set | (cur & ~clr);
   endfunction

endpackage

// ### ewc_frame_if.sv
// ewc_frame_if: received-frame facts and storage decisions between control and frame gate
// assumes: frame facts are valid in the cycle of frameEnd
`timescale 1ns/1ps
`default_nettype none
interface ewc_frame_if #(parameter int NUM_FILTERS = 4);
   logic                   frameEnd;
   logic                   frameGood;
   logic [NUM_FILTERS-1:0] filterHits;
   logic                   isWakeFrame;
   logic [NUM_FILTERS-1:0] filterEnMask;
   logic                   bypassWake;
   logic                   keepWake;
   logic                   goodArmed;
   logic                   patternArmed;
   logic                   suspended;
   logic                   goodFrameHit;
   logic                   patternHit;
   logic                   storeFrame;
   logic                   markWake;

   modport gate (input frameEnd, frameGood, filterHits, isWakeFrame, filterEnMask, bypassWake,
                 keepWake, goodArmed, patternArmed, suspended,
                 output goodFrameHit, patternHit, storeFrame, markWake);
   modport ctrl (output frameEnd, frameGood, filterHits, isWakeFrame, filterEnMask, bypassWake,
                 keepWake, goodArmed, patternArmed, suspended,
                 input goodFrameHit, patternHit, storeFrame, markWake);
endinterface
`default_nettype wire

// ### ewc_frame_gate.sv
// ewc_frame_gate: decides whether a received frame wakes the device and whether it is stored
// assumes: purely combinational; caller registers the results
`timescale 1ns/1ps
`default_nettype none
module ewc_frame_gate
   import ewc_pkg::*;
(
   ewc_frame_if.gate fr
);
   wire filterPass;
   wire goodEnd;
   wire goodWake;
   wire patWake;
   wire wakeFrame;
   wire wakeStore;
   wire normalStore;

   assign filterPass  = |(fr.filterHits & fr.filterEnMask);
   assign goodEnd     = fr.frameEnd & fr.frameGood;
   assign goodWake    = goodEnd & filterPass & fr.goodArmed & fr.suspended;
   assign patWake     = goodEnd & fr.isWakeFrame & fr.patternArmed & fr.suspended;
   assign wakeFrame   = goodWake | patWake;
   // wake frame kept only on request; bypass skips the filters for it
   assign wakeStore   = wakeFrame & fr.keepWake & (fr.bypassWake | filterPass);
   // once awake, every good frame passing the filters goes to the fifo
   assign normalStore = goodEnd & filterPass & ~fr.suspended;

   assign fr.goodFrameHit = goodWake;
   assign fr.patternHit   = patWake;
   assign fr.storeFrame   = wakeStore | normalStore;
   assign fr.markWake     = wakeStore;
endmodule
`default_nettype wire

// ### ewc_wake_ctrl.sv
// ewc_wake_ctrl: wake-event control with AHB-Lite register slave, suspend state and fifo marking
// assumes: inputs synchronous to clock; one AHB-Lite master; zero-wait slave while clockEn high
`timescale 1ns/1ps
`default_nettype none
module ewc_wake_ctrl
   import ewc_pkg::*;
#(
   parameter int NUM_FILTERS = 4
)
(
   input  wire logic                   clock,
   input  wire logic                   sys_rst,
   input  wire logic                   clockEn,
   // ahb-lite slave
   input  wire logic                   hsel,
   input  wire logic [11:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic                        hresp,
   output logic [31:0]                 hrdata,
   // usb device side
   input  wire logic                   usbSuspend,
   input  wire logic                   usbResume,
   output logic                        remoteWake,
   output logic                        suspendedOut,
   output logic [1:0]                  lowPowerState,
   // wake sources
   input  wire logic                   phyIrq,
   input  wire logic                   macWakeEvent,
   // receive path
   input  wire logic                   rxFrameEnd,
   input  wire logic                   rxFrameGood,
   input  wire logic [NUM_FILTERS-1:0] rxFilterHits,
   input  wire logic                   rxIsWakeFrame,
   output logic                        fifoWrite,
   output logic                        fifoWakeFlag
);

   if (NUM_FILTERS < 1 || NUM_FILTERS > 8) begin : g_bad_filters
      $error("NUM_FILTERS must be 1 to 8");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers and state

   logic                   phyWakeEn_reg;
   logic                   lanWakeEn_reg;
   logic [1:0]             wakePendingStatus_reg;
   logic [1:0]             suspSel_reg;
   logic                   filterWakeEn_reg;
   logic                   keepWake_reg;
   logic                   bypassWake_reg;
   logic [NUM_FILTERS-1:0] filterEn_reg;
   logic [WSR_WIDTH-1:0]   wakeSource_reg;
   ewc_power_t             power_reg;
   ewc_power_t             power_next;
   logic [1:0]             lowPower_reg;
   logic                   remoteWake_reg;
   logic                   fifoWrite_reg;
   logic                   fifoWakeFlag_reg;

   // bus data phase bookkeeping
   logic                   wrPend_reg;
   logic [11:0]            wrAddr_reg;
   logic [31:0]            rdata_reg;
   logic [31:0]            rdata_next;

   ewc_frame_if #(.NUM_FILTERS(NUM_FILTERS)) frm ();

   ewc_frame_gate u_gate (
      .fr (frm)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // bus decode

   wire addrPhase;
   wire doWrite;
   wire selPmc;
   wire selWcs1;
   wire selRfc;
   wire selWsr;

   assign addrPhase = clockEn & hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == HSIZE_WORD);
   assign doWrite   = clockEn & wrPend_reg;
   assign selPmc    = (wrAddr_reg == PMC_OFFSET);
   assign selWcs1   = (wrAddr_reg == WCS1_OFFSET);
   assign selRfc    = (wrAddr_reg == RFC_OFFSET);
   assign selWsr    = (wrAddr_reg == WSR_OFFSET);

   // stall the master while the clock enable freezes the block
   assign hreadyout = clockEn;
   assign hresp     = HRESP_OKAY;
   assign hrdata    = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // wake decisions

   wire [1:0] wpsClearReq;
   wire [1:0] wpsSet;
   wire [1:0] wpsHold;
   wire [1:0] wpsClear;
   wire       macArmed;
   wire       phyWakeReq;
   wire       macWakeReq;
   wire       inStateThree;
   wire       inStateTwo;
   wire       phyAllowed;
   wire       macAllowed;
   wire       wakeNow;
   wire [WSR_WIDTH-1:0] srcSet;
   wire [WSR_WIDTH-1:0] srcClear;

   assign wpsClearReq = (doWrite & selPmc) ? hwdata[PMC_WPS_LO +: 2] : 2'h0;
   assign wpsSet      = {macWakeEvent | frm.goodFrameHit | frm.patternHit, phyIrq};
   // a live source holds its pending bit against software clears
   assign wpsHold     = {macWakeEvent, phyIrq};
   assign wpsClear    = wpsClearReq & ~wpsHold;

   assign macArmed     = lanWakeEn_reg | filterWakeEn_reg;
   assign phyWakeReq   = phyWakeEn_reg & wakePendingStatus_reg[0];
   assign macWakeReq   = macArmed & wakePendingStatus_reg[1];
   assign inStateThree = (lowPower_reg == SUSP_THREE);
   assign inStateTwo   = (lowPower_reg == SUSP_TWO);
   // link change and pattern wake are refused only in state two
   assign phyAllowed   = ~inStateTwo;
   assign macAllowed   = ~inStateTwo & (lanWakeEn_reg | inStateThree);
   assign wakeNow      = (power_reg == EWC_SUSPENDED) &
                         ((phyWakeReq & phyAllowed) | (macWakeReq & macAllowed));

   assign srcSet[WSR_LINK_CHANGE] = wakeNow & phyWakeReq & phyAllowed;
   assign srcSet[WSR_GOOD_FRAME]  = frm.goodFrameHit;
   assign srcSet[WSR_PATTERN]     = frm.patternHit | (wakeNow & macWakeReq & macAllowed & lanWakeEn_reg);
   assign srcClear = (doWrite & selWsr) ? hwdata[WSR_WIDTH-1:0] : '0;

   ////////////////////////////////////////////////////////////////////////////////
   // frame gate hookup

   assign frm.frameEnd     = rxFrameEnd & clockEn;
   assign frm.frameGood    = rxFrameGood;
   assign frm.filterHits   = rxFilterHits;
   assign frm.isWakeFrame  = rxIsWakeFrame;
   assign frm.filterEnMask = filterEn_reg;
   assign frm.bypassWake   = bypassWake_reg;
   assign frm.keepWake     = keepWake_reg;
   // good-frame wake needs filter wake with lan wake off, in state three
   assign frm.goodArmed    = filterWakeEn_reg & ~lanWakeEn_reg & inStateThree;
   assign frm.patternArmed = lanWakeEn_reg & ~inStateTwo;
   assign frm.suspended    = (power_reg == EWC_SUSPENDED);

   ////////////////////////////////////////////////////////////////////////////////
   // power state machine

   always_comb begin
      power_next = power_reg;
      case (power_reg)
         EWC_NORMAL: begin
            if (usbSuspend) begin
               power_next = EWC_SUSPENDED;
            end
         end
         EWC_SUSPENDED: begin
            if (wakeNow || usbResume) begin
               power_next = EWC_NORMAL;
            end
         end
         default: begin
            power_next = EWC_NORMAL;
         end
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         power_reg      <= EWC_NORMAL;
         lowPower_reg   <= SUSP_SEL_RESET;
         remoteWake_reg <= 1'b0;
      end else if (clockEn) begin
         power_reg      <= power_next;
         remoteWake_reg <= wakeNow;
         if (power_reg == EWC_NORMAL && usbSuspend) begin
            lowPower_reg <= suspSel_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sticky status

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wakePendingStatus_reg <= 2'h0;
         wakeSource_reg        <= '0;
      end else if (clockEn) begin
         wakePendingStatus_reg <= wpsSet | (wakePendingStatus_reg & ~wpsClear);
         wakeSource_reg        <= ewc_sticky(wakeSource_reg, srcSet, srcClear);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control register writes

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         phyWakeEn_reg    <= 1'b0;
         lanWakeEn_reg    <= 1'b0;
         suspSel_reg      <= SUSP_SEL_RESET;
         filterWakeEn_reg <= 1'b0;
         keepWake_reg     <= 1'b0;
         bypassWake_reg   <= 1'b0;
         filterEn_reg     <= '0;
      end else if (doWrite) begin
         if (selPmc) begin
            phyWakeEn_reg <= hwdata[PMC_PHY_WAKE_ENABLE];
            lanWakeEn_reg <= hwdata[PMC_LAN_WAKE_EN];
            suspSel_reg   <= hwdata[PMC_SUSP_SEL_LO +: 2];
         end
         if (selWcs1) begin
            filterWakeEn_reg <= hwdata[WCS1_FILTER_WAKE_EN];
            keepWake_reg     <= hwdata[WCS1_KEEP_WAKE];
         end
         if (selRfc) begin
            bypassWake_reg <= hwdata[RFC_BYPASS_WAKE];
            filterEn_reg   <= hwdata[RFC_FILTER_EN_LO +: NUM_FILTERS];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus phases and read data

   always_comb begin
      rdata_next = WORD_ZERO;
      case (haddr)
         PMC_OFFSET: begin
            rdata_next[PMC_PHY_WAKE_ENABLE]        = phyWakeEn_reg;
            rdata_next[PMC_LAN_WAKE_EN]        = lanWakeEn_reg;
            rdata_next[PMC_WPS_LO +: 2]        = wakePendingStatus_reg;
            rdata_next[PMC_SUSP_SEL_LO +: 2]   = suspSel_reg;
            rdata_next[PMC_CUR_STATE_LO +: 2]  = lowPower_reg;
            rdata_next[PMC_SUSPENDED]          = (power_reg == EWC_SUSPENDED);
         end
         WCS1_OFFSET: begin
            rdata_next[WCS1_FILTER_WAKE_EN] = filterWakeEn_reg;
            rdata_next[WCS1_KEEP_WAKE]      = keepWake_reg;
         end
         RFC_OFFSET: begin
            rdata_next[RFC_BYPASS_WAKE]               = bypassWake_reg;
            rdata_next[RFC_FILTER_EN_LO +: NUM_FILTERS] = filterEn_reg;
         end
         WSR_OFFSET: begin
            rdata_next[WSR_WIDTH-1:0] = wakeSource_reg;
         end
         default: begin
            rdata_next = WORD_ZERO;
         end
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wrPend_reg <= 1'b0;
         wrAddr_reg <= 12'h000;
         rdata_reg  <= WORD_ZERO;
      end else if (clockEn) begin
         wrPend_reg <= addrPhase & hwrite;
         if (addrPhase) begin
            wrAddr_reg <= haddr;
            rdata_reg  <= hwrite ? WORD_ZERO : rdata_next;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // fifo write strobe with wake-frame flag

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         fifoWrite_reg    <= 1'b0;
         fifoWakeFlag_reg <= 1'b0;
      end else if (clockEn) begin
         fifoWrite_reg    <= frm.storeFrame;
         fifoWakeFlag_reg <= frm.markWake;
      end
   end

   assign remoteWake    = remoteWake_reg;
   assign suspendedOut  = (power_reg == EWC_SUSPENDED);
   assign lowPowerState = lowPower_reg;
   assign fifoWrite     = fifoWrite_reg;
   assign fifoWakeFlag  = fifoWakeFlag_reg;

endmodule
`default_nettype wire

// ### ewc_wake_chk.sv
// ewc_wake_chk: port-level assertions for the wake-event control block
// assumes: bound into ewc_wake_ctrl, one clock domain, reset sys_rst
`timescale 1ns/1ps
`default_nettype none
module ewc_wake_chk
   import ewc_pkg::*;
#(
   parameter int NUM_FILTERS = 4
)
(
   input wire logic       clock,
   input wire logic       sys_rst,
   input wire logic       clockEn,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic       usbSuspend,
   input wire logic       remoteWake,
   input wire logic       suspendedOut,
   input wire logic [1:0] lowPowerState,
   input wire logic       rxFrameEnd,
   input wire logic       rxFrameGood,
   input wire logic       fifoWrite,
   input wire logic       fifoWakeFlag
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////
   sequence s_leave;
      $past(suspendedOut) && !suspendedOut;
   endsequence
   sequence s_goodTaken;
      $past(rxFrameEnd) && $past(rxFrameGood);
   endsequence
   property p_okay; hresp == HRESP_OKAY; endproperty
   property p_stall; hreadyout == clockEn; endproperty
   property p_wakeExit; remoteWake && $past(clockEn) |-> s_leave; endproperty
   property p_wakePulse; remoteWake && clockEn |=> !remoteWake; endproperty
   property p_store; fifoWrite && $past(clockEn) |-> s_goodTaken; endproperty
   property p_flag; fifoWakeFlag |-> fifoWrite; endproperty
   property p_flagSusp; fifoWakeFlag && $past(clockEn) |-> $past(suspendedOut); endproperty
   property p_state; suspendedOut && $past(suspendedOut) |-> $stable(lowPowerState); endproperty
   property p_enter; $rose(suspendedOut) |-> $past(usbSuspend); endproperty
   property p_freeze; !clockEn |=> $stable(suspendedOut) && $stable(lowPowerState); endproperty
   ////////////////////////////////////////
   a_okay: assert property (p_okay) else $error("bus response not okay");
   a_stall: assert property (p_stall) else $error("ready differs from clock enable");
   a_wakeExit: assert property (p_wakeExit) else $error("remote wake without leaving suspend");
   a_wakePulse: assert property (p_wakePulse) else $error("remote wake longer than one cycle");
   a_store: assert property (p_store) else $error("frame stored without good frame end");
   a_flag: assert property (p_flag) else $error("wake flag without fifo write");
   a_flagSusp: assert property (p_flagSusp) else $error("wake flag on frame seen awake");
   a_state: assert property (p_state) else $error("low-power state moved while suspended");
   a_enter: assert property (p_enter) else $error("suspend entered without signalling");
   a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
endmodule
bind ewc_wake_ctrl ewc_wake_chk #(.NUM_FILTERS(NUM_FILTERS)) i_ewc_wake_chk (
   .clock(clock), .sys_rst(sys_rst), .clockEn(clockEn), .hreadyout(hreadyout), .hresp(hresp),
   .usbSuspend(usbSuspend), .remoteWake(remoteWake), .suspendedOut(suspendedOut),
   .lowPowerState(lowPowerState), .rxFrameEnd(rxFrameEnd), .rxFrameGood(rxFrameGood),
   .fifoWrite(fifoWrite), .fifoWakeFlag(fifoWakeFlag));
`default_nettype wire

// ### ewc_host_model.sv
// ewc_host_model: host side register master, single word ahb-lite transfers
// assumes: hreadyout of the one slave is the bus ready
`timescale 1ns/1ps
`default_nettype none
module ewc_host_model
   import ewc_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        hreadyout,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [11:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = HSIZE_WORD;
      hwdata = 32'h0000_0000;
   end
   // one transfer: address phase held until ready, then data phase until ready
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= w ? d : ~hwdata;
      do @(posedge clock); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
endmodule
`default_nettype wire

// ### ewc_wake_ctrl_tb_top.sv
// ewc_wake_ctrl_tb_top: self-checking bench for the wake-event control block
// assumes: host model drives the register bus, bench drives wake and frame inputs
`timescale 1ns/1ps
`default_nettype none
module ewc_wake_ctrl_tb_top
   import ewc_pkg::*;
;
   logic        clock, sys_rst, clockEn, hsel, hwrite, hreadyout, hresp, usbSuspend, usbResume;
   logic        remoteWake, suspendedOut, phyIrq, macWakeEvent, rxFrameEnd, rxFrameGood;
   logic        rxIsWakeFrame, fifoWrite, fifoWakeFlag, st, fl, seen, g;
   logic [1:0]  htrans, lowPowerState;
   logic [2:0]  hsize;
   logic [3:0]  rxFilterHits, en, h;
   logic [11:0] haddr;
   logic [31:0] hwdata, hrdata, q;
   int          errors = 0, n_checks = 0, cycles = 0, s;
   ewc_wake_ctrl #(.NUM_FILTERS(4)) i_ewc_wake_ctrl (.clock(clock), .sys_rst(sys_rst), .clockEn(clockEn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .usbSuspend(usbSuspend),
      .usbResume(usbResume), .remoteWake(remoteWake), .suspendedOut(suspendedOut),
      .lowPowerState(lowPowerState), .phyIrq(phyIrq), .macWakeEvent(macWakeEvent),
      .rxFrameEnd(rxFrameEnd), .rxFrameGood(rxFrameGood), .rxFilterHits(rxFilterHits),
      .rxIsWakeFrame(rxIsWakeFrame), .fifoWrite(fifoWrite), .fifoWakeFlag(fifoWakeFlag));
   ewc_host_model i_ewc_host_model (.clock(clock), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   ////////////////////////////////////////
   task conclude;
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] sv, input logic [31:0] ev);
      n_checks++;
      if (sv !== ev) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, sv, ev);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      i_ewc_host_model.xfer(1'b1, a, d, q);
   endtask
   task rdChk(input logic [11:0] a, input logic [31:0] ev);
      i_ewc_host_model.xfer(1'b0, a, 32'h0000_0000, q);
      chk(q, ev);
   endtask
   function automatic logic [31:0] pmc(input logic phy, input logic lan, input logic [1:0] sel);
      pmc = WORD_ZERO;
      pmc[PMC_PHY_WAKE_ENABLE] = phy;
      pmc[PMC_LAN_WAKE_EN] = lan;
      pmc[PMC_SUSP_SEL_LO+:2] = sel;
   endfunction
   function automatic logic expStore(input logic gd, input logic [3:0] hits);
      expStore = gd && ((hits & en) != 4'h0);
   endfunction
   task clr;
      wr(PMC_OFFSET, 32'h0000_0030);
      wr(WSR_OFFSET, 32'h0000_0007);
   endtask
   task susp;
      @(posedge clock);
      usbSuspend <= 1'b1;
      @(posedge clock);
      usbSuspend <= 1'b0;
      #1;
   endtask
   task src(input int b, input logic v);
      @(posedge clock);
      if (b == 0) phyIrq <= v;
      else macWakeEvent <= v;
   endtask
   task waitWake;
      seen = 1'b0;
      repeat (6) begin
         @(posedge clock);
         #1;
         if (remoteWake === 1'b1) seen = 1'b1;
      end
   endtask
   task frame(input logic gd, input logic [3:0] hits, input logic wk);
      @(posedge clock);
      rxFrameEnd <= 1'b1;
      rxFrameGood <= gd;
      rxFilterHits <= hits;
      rxIsWakeFrame <= wk;
      @(posedge clock);
      rxFrameEnd <= 1'b0;
      rxFrameGood <= ~gd;
      rxFilterHits <= ~hits;
      rxIsWakeFrame <= ~wk;
      #1;
      st = fifoWrite;
      fl = fifoWakeFlag;
   endtask
   ////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles > 20000) begin
         errors++;
         conclude;
      end
   end
   initial begin
      {sys_rst, clockEn} = 2'b11;
      {usbSuspend, usbResume, phyIrq, macWakeEvent, rxFrameEnd, rxFrameGood, rxIsWakeFrame} = 7'h00;
      rxFilterHits = 4'h0;
      s = $urandom(45835);
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      for (int i = 0; i < 5; i++) rdChk(12'(i * 4), 32'h0000_0000);
      wr(12'h010, 32'hFFFF_FFFF);
      rdChk(12'h010, 32'h0000_0000);
      clockEn <= 1'b0;
      fork
         rdChk(PMC_OFFSET, 32'h0000_0000);
         begin repeat (3) @(posedge clock); clockEn <= 1'b1; end
      join
      // pending bits: sticky while source high, then arm and wake at once
      for (int b = 0; b < 2; b++) begin
         src(b, 1'b1);
         repeat (2) @(posedge clock);
         wr(PMC_OFFSET, 32'h0000_0010 << b);
         rdChk(PMC_OFFSET, 32'h0000_0010 << b);
         src(b, 1'b0);
         clr;
         rdChk(PMC_OFFSET, 32'h0000_0000);
         src(b, 1'b1);
         src(b, 1'b0);
         wr(PMC_OFFSET, pmc(b == 0, b == 1, SUSP_ZERO));
         susp;
         waitWake;
         chk(seen, 1'b1);
         rdChk(WSR_OFFSET, (b == 0) ? 32'h1 : 32'h4);
         clr;
      end
      // link change wake in every suspend state except state two, which refuses it
      for (int sl = 0; sl < 4; sl++) begin
         wr(PMC_OFFSET, pmc(1'b1, 1'b0, 2'(sl)));
         susp;
         chk(lowPowerState, sl);
         src(0, 1'b1);
         src(0, 1'b0);
         waitWake;
         chk(seen, sl != 2);
         rdChk(WSR_OFFSET, (sl != 2) ? 32'h1 : 32'h0);
         if (sl == 2) begin
            rdChk(PMC_OFFSET, 32'h0000_6211);
            @(posedge clock);
            usbResume <= 1'b1;
            @(posedge clock);
            usbResume <= 1'b0;
            rdChk(PMC_OFFSET, 32'h0000_2211);
         end
         clr;
      end
      // good-frame wake, with and without keeping the waking frame
      for (int k = 0; k < 2; k++) begin
         en = 4'($urandom_range(15, 1));
         wr(RFC_OFFSET, {20'h0, en, 8'h00});
         wr(WCS1_OFFSET, {30'h0, 1'(k), 1'b1});
         wr(PMC_OFFSET, pmc(1'b0, 1'b0, SUSP_THREE));
         susp;
         frame(1'b0, en, 1'b0);
         chk(st, 1'b0);
         frame(1'b1, ~en, 1'b0);
         chk(st, 1'b0);
         frame(1'b1, en, 1'b0);
         chk({st, fl}, {1'(k), 1'(k)});
         waitWake;
         chk(seen, 1'b1);
         rdChk(WSR_OFFSET, 32'h2);
         repeat (8) begin
            g = 1'($urandom);
            h = 4'($urandom);
            frame(g, h, 1'b0);
            chk(st, expStore(g, h));
         end
         clr;
      end
      // pattern wake with kept frame and filters bypassed
      en = 4'h0;
      wr(WCS1_OFFSET, 32'h2);
      wr(RFC_OFFSET, 32'h1);
      wr(PMC_OFFSET, pmc(1'b0, 1'b1, SUSP_THREE));
      susp;
      frame(1'b1, 4'h0, 1'b1);
      chk({st, fl}, 2'b11);
      waitWake;
      chk(seen, 1'b1);
      rdChk(WSR_OFFSET, 32'h4);
      frame(1'b1, 4'hF, 1'b0);
      chk(st, expStore(1'b1, 4'hF));
      conclude;
   end
endmodule
`default_nettype wire
